// ==== hdl/serc_read_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Read: opcode then 24 address bits; only low array bits are used.
// - After the last address bit, data shifts out most significant bit first.
// - Continued clocking advances the read pointer and sends the next byte.
// - Past the highest array address the pointer wraps to zero.
// - Chip select high ends the read and releases the serial output.
// - Id page read: bits 7..0 give the byte offset; upper bits other than select bit 10 are ignored.
// - Read status shifts the status byte out after the last command bit.
// - Read status is served at any time, even during a write cycle.
// - Lock status read uses select bit 10 high; other address bits ignored.
// - Lock status byte bit 0 is one when the id page is locked.
// - Lock status read is served at any time, even during a write cycle.
// - During hold the output floats and serial input changes are ignored.
// - After power-up the device idles with writes disabled.
// - A completed write returns the device to the write-disabled state.
// - The internal write starts on chip select rising after whole bytes.
// - Array accesses during a write cycle are ignored.
// - Unknown opcodes are ignored; the output floats for that selection.
// - During a write cycle only read status and lock status read are taken; ready bit shows busy.
module serc_read_ctrl #(
   parameter int ARRAY_W = serc_pkg::ARRAY_AW
) (
   // Clock, reset and enable.
   input  wire logic                            sys_clk_in,
   input  wire logic                            rstn_in,
   input  wire logic                            ce_in,
   // Serial link pins.
   input  wire logic                            spi_cs_n_in,
   input  wire logic                            spi_sck_in,
   input  wire logic                            spi_si_in,
   input  wire logic                            spi_hold_n_in,
   output logic                                 spi_so_out,
   output logic                                 spi_so_oe_out,
   // Status from the write engine.
   input  wire logic [serc_pkg::BYTE_BITS-1:0]  status_in,
   input  wire logic                            id_locked_in,
   input  wire logic                            write_busy_in,
   input  wire logic                            write_done_in,
   // Write hand-off to the write engine.
   output logic                                 write_start_out,
   output logic                                 write_byte_out,
   output logic      [serc_pkg::OPC_BITS-1:0]   write_opcode_out,
   output logic      [serc_pkg::ADDR_BITS-1:0]  write_addr_out,
   output logic      [serc_pkg::BYTE_BITS-1:0]  write_data_out,
   output logic                                 wel_out,
   // Memory load port.
   input  wire logic                            mem_wr_en_in,
   input  wire logic                            mem_wr_id_in,
   input  wire logic [ARRAY_W-1:0]              mem_wr_addr_in,
   input  wire logic [serc_pkg::BYTE_BITS-1:0]  mem_wr_data_in
);
   import serc_pkg::*;

   serc_state_e              state;
   logic [3:0]               pins_s;
   logic                     cs_s, sck_s, si_s, hold_n_s;
   logic                     sck_q, cs_q;
   logic                     sck_rise, sck_fall, hold_act, rise_ok, fall_ok, cs_rise;
   logic [CNT_W-1:0]         bit_cnt;
   logic [ADDR_BITS-1:0]     rx_sr;
   logic [ADDR_BITS-1:0]     next_rx;
   logic [OPC_BITS-1:0]      opcode;
   logic                     opc_done, addr_done, byte_load;
   logic [1:0]               src;
   logic [ARRAY_W-1:0]       ptr_arr;
   logic [ID_AW-1:0]         ptr_id;
   logic [BYTE_BITS-1:0]     arr_rd, id_rd, src_byte;
   logic [BYTE_BITS-1:0]     tx_sr;
   logic [2:0]               tx_cnt;
   logic                     tx_live, wr_have;

   // Pins cross into the system clock domain.
   serc_sync #(.W(4), .RST_VAL(PIN_RST)) u_sync (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .ce_in      (ce_in),
      .async_in   ({spi_cs_n_in, spi_sck_in, spi_si_in, spi_hold_n_in}),
      .sync_out   (pins_s)
   );
   assign {cs_s, sck_s, si_s, hold_n_s} = pins_s;

   // Delayed copies for edge detection.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sck_q <= 1'b0;
         cs_q  <= 1'b1;
      end else if (ce_in) begin
         sck_q <= sck_s;
         cs_q  <= cs_s;
      end
   end

   // Clock edges count only while selected and not on hold.
   assign sck_rise = sck_s & ~sck_q;
   assign sck_fall = ~sck_s & sck_q;
   assign hold_act = ~hold_n_s;
   assign rise_ok  = sck_rise & ~cs_s & ~hold_act;
   assign fall_ok  = sck_fall & ~cs_s & ~hold_act;
   assign cs_rise  = cs_s & ~cs_q;
   assign next_rx  = {rx_sr[ADDR_BITS-2:0], si_s};
   assign opc_done  = rise_ok && state == SERC_OPCODE && bit_cnt == CNT_OPC_LAST;
   assign addr_done = rise_ok && state == SERC_ADDR && bit_cnt == CNT_ADDR_LAST;
   assign byte_load = fall_ok && state == SERC_DATA && tx_cnt == 3'h0;

   // Selection state machine.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= SERC_IDLE;
      end else if (ce_in) begin
         if (cs_s) begin
            state <= SERC_IDLE;
         end else if (state == SERC_IDLE) begin
            state <= SERC_OPCODE;
         end else if (opc_done) begin
            if (next_rx[OPC_BITS-1:0] == OPC_READ_STATUS) begin
               state <= SERC_DATA;
            end else if (write_busy_in && next_rx[OPC_BITS-1:0] != OPC_READ_ID_PAGE) begin
               state <= SERC_IGNORE;
            end else begin
               case (next_rx[OPC_BITS-1:0])
                  OPC_READ, OPC_READ_ID_PAGE, OPC_WRITE, OPC_WRITE_ID: begin
                     state <= SERC_ADDR;
                  end
                  OPC_WRITE_STATUS: begin
                     state <= SERC_WRDATA;
                  end
                  default: begin
                     state <= SERC_IGNORE;
                  end
               endcase
            end
         end else if (addr_done) begin
            // While busy only the lock status read may go on to the data phase.
            if (write_busy_in && !next_rx[ID_SPACE_SELECT_BIT]) begin
               state <= SERC_IGNORE;
            end else if (opcode == OPC_READ || opcode == OPC_READ_ID_PAGE) begin
               state <= SERC_DATA;
            end else begin
               state <= SERC_WRDATA;
            end
         end
      end
   end

   // Bit counter and receive shift register, sampled on rising clock edges.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bit_cnt <= '0;
         rx_sr   <= '0;
         opcode  <= '0;
      end else if (ce_in) begin
         if (state == SERC_IDLE) begin
            bit_cnt <= '0;
         end else if (rise_ok) begin
            bit_cnt <= bit_cnt + 6'h01;
            rx_sr   <= next_rx;
         end
         if (opc_done) begin
            opcode <= next_rx[OPC_BITS-1:0];
         end
      end
   end

   // Read pointers and byte source, set when the address completes; the status source is set when the opcode completes.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ptr_arr <= '0;
         ptr_id  <= '0;
         src     <= SRC_ARRAY;
      end else if (ce_in) begin
         if (opc_done) begin
            src <= SRC_STATUS;
         end else if (addr_done) begin
            ptr_arr <= next_rx[ARRAY_W-1:0];
            ptr_id  <= next_rx[ID_AW-1:0];
            if (opcode == OPC_READ) begin
               src <= SRC_ARRAY;
            end else if (next_rx[ID_SPACE_SELECT_BIT]) begin
               src <= SRC_LOCK;
            end else begin
               src <= SRC_IDPAGE;
            end
         end else if (byte_load) begin
            // Natural wrap of the pointer width takes the top address to zero.
            if (src == SRC_ARRAY) begin
               ptr_arr <= ptr_arr + 1'b1;
            end
            if (src == SRC_IDPAGE) begin
               ptr_id <= ptr_id + 1'b1;
            end
         end
      end
   end

   // Array and identification page storage.
   serc_mem #(.AW(ARRAY_W), .DW(BYTE_BITS)) u_array (
      .sys_clk_in  (sys_clk_in),
      .rstn_in     (rstn_in),
      .ce_in       (ce_in),
      .wr_en_in    (mem_wr_en_in & ~mem_wr_id_in),
      .wr_addr_in  (mem_wr_addr_in),
      .wr_data_in  (mem_wr_data_in),
      .rd_addr_in  (ptr_arr),
      .rd_data_out (arr_rd)
   );
   serc_mem #(.AW(ID_AW), .DW(BYTE_BITS)) u_idpage (
      .sys_clk_in  (sys_clk_in),
      .rstn_in     (rstn_in),
      .ce_in       (ce_in),
      .wr_en_in    (mem_wr_en_in & mem_wr_id_in),
      .wr_addr_in  (mem_wr_addr_in[ID_AW-1:0]),
      .wr_data_in  (mem_wr_data_in),
      .rd_addr_in  (ptr_id),
      .rd_data_out (id_rd)
   );

   // Byte to send next; the ready bit follows the write engine.
   always_comb begin
      case (src)
         SRC_ARRAY:  src_byte = arr_rd;
         SRC_IDPAGE: src_byte = id_rd;
         SRC_LOCK: begin
            src_byte           = '0;
            src_byte[LOCK_BIT] = id_locked_in;
         end
         default: begin
            src_byte            = status_in;
            src_byte[READY_BIT] = write_busy_in;
         end
      endcase
   end

   // Transmit shifter, changed on falling clock edges.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_sr   <= '0;
         tx_cnt  <= '0;
         tx_live <= 1'b0;
      end else if (ce_in) begin
         if (state != SERC_DATA) begin
            tx_cnt  <= '0;
            tx_live <= 1'b0;
         end else if (byte_load) begin
            tx_sr   <= src_byte;
            tx_cnt  <= 3'h7;
            tx_live <= 1'b1;
         end else if (fall_ok) begin
            tx_sr  <= {tx_sr[BYTE_BITS-2:0], 1'b0};
            tx_cnt <= tx_cnt - 3'h1;
         end
      end
   end

   // Output driver: floats when deselected, on hold or outside data.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         spi_so_oe_out <= 1'b0;
      end else if (ce_in) begin
         spi_so_oe_out <= tx_live && state == SERC_DATA && !cs_s && !hold_act;
      end
   end
   assign spi_so_out = tx_sr[BYTE_BITS-1];

   // Write enable latch: off at power-up and after a completed write.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wel_out <= 1'b0;
      end else if (ce_in) begin
         if (opc_done && !write_busy_in && next_rx[OPC_BITS-1:0] == OPC_WRITE_ENABLE) begin
            wel_out <= 1'b1;
         end else if (write_done_in) begin
            wel_out <= 1'b0;
         end else if (opc_done && !write_busy_in && next_rx[OPC_BITS-1:0] == OPC_WRITE_DIS) begin
            wel_out <= 1'b0;
         end
      end
   end

   // Write hand-off: address, data bytes, and start on chip select rising.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         write_start_out  <= 1'b0;
         write_byte_out   <= 1'b0;
         write_opcode_out <= '0;
         write_addr_out   <= '0;
         write_data_out   <= '0;
         wr_have          <= 1'b0;
      end else if (ce_in) begin
         write_byte_out  <= 1'b0;
         write_start_out <= cs_rise && state == SERC_WRDATA && wr_have && wel_out &&
                            bit_cnt[2:0] == 3'h0 && !write_busy_in;
         if (state == SERC_IDLE) begin
            wr_have <= 1'b0;
         end
         if (opc_done) begin
            write_opcode_out <= next_rx[OPC_BITS-1:0];
         end
         if (addr_done) begin
            write_addr_out <= next_rx;
         end
         if (rise_ok && state == SERC_WRDATA && bit_cnt[2:0] == 3'h7) begin
            write_data_out <= next_rx[BYTE_BITS-1:0];
            write_byte_out <= 1'b1;
            wr_have        <= 1'b1;
         end
      end
   end

   // Checks on the device side.
   hold_float_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      ce_in && hold_act |=> !spi_so_oe_out)
      else $error("Output driven during hold.");
   cs_release_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      ce_in && cs_s |=> !spi_so_oe_out ##0 state == SERC_IDLE)
      else $error("Output not released after deselect.");
   ignore_float_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      state == SERC_IGNORE |-> !spi_so_oe_out)
      else $error("Output driven for an ignored opcode.");
   busy_ignore_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      ce_in && opc_done && write_busy_in && next_rx[7:0] != OPC_READ_STATUS
      && next_rx[7:0] != OPC_READ_ID_PAGE |=> state == SERC_IGNORE)
      else $error("Command taken during write cycle.");
   status_any_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      ce_in && opc_done && next_rx[7:0] == OPC_READ_STATUS
      |=> state == SERC_DATA && src == SRC_STATUS)
      else $error("Read status not served.");
   ptr_step_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      ce_in && byte_load && src == SRC_ARRAY
      |=> ptr_arr == ARRAY_W'($past(ptr_arr) + 1'b1))
      else $error("Array pointer did not step or wrap.");
   msb_first_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      ce_in && byte_load |=> spi_so_out == $past(src_byte[7]) ##1 tx_live)
      else $error("Byte not sent most significant bit first.");
   lock_byte_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      src == SRC_LOCK |-> src_byte == {7'h00, id_locked_in})
      else $error("Lock status byte wrong.");
   wel_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      ce_in && write_done_in && !opc_done |=> !wel_out)
      else $error("Write enable kept after completed write.");
   wr_start_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      write_start_out |-> $past(cs_rise) && $past(wel_out))
      else $error("Write started without chip select rising.");

endmodule // serc_read_ctrl

// ==== inc/serc_pkg.sv ====
package serc_pkg;

   // Link widths.
   localparam int OPC_BITS  = 8;
   localparam int ADDR_BITS = 24;
   localparam int BYTE_BITS = 8;
   localparam int ARRAY_AW  = 17;
   localparam int ID_AW     = 8;
   localparam int CNT_W     = 6;

   // Bit positions inside the received address and the returned bytes.
   localparam int ID_SPACE_SELECT_BIT = 10;
   localparam int READY_BIT           = 0;
   localparam int LOCK_BIT            = 0;

   // Bit counter marks: last opcode bit and last address bit.
   localparam logic [CNT_W-1:0] CNT_OPC_LAST  = 6'h07;
   localparam logic [CNT_W-1:0] CNT_ADDR_LAST = 6'h1f;

   // Instruction codes, sent most significant bit first.
   localparam logic [OPC_BITS-1:0] OPC_READ         = 8'h03;
   localparam logic [OPC_BITS-1:0] OPC_READ_ID_PAGE = 8'h83;
   localparam logic [OPC_BITS-1:0] OPC_READ_STATUS  = 8'h05;
   localparam logic [OPC_BITS-1:0] OPC_WRITE_ENABLE = 8'h06;
   localparam logic [OPC_BITS-1:0] OPC_WRITE_DIS    = 8'h04;
   localparam logic [OPC_BITS-1:0] OPC_WRITE        = 8'h02;
   localparam logic [OPC_BITS-1:0] OPC_WRITE_ID     = 8'h82;
   localparam logic [OPC_BITS-1:0] OPC_WRITE_STATUS = 8'h01;

   // Reset values of the synchronised pins {cs_n, sck, si, hold_n}.
   localparam logic [3:0] PIN_RST = 4'h9;

   // Source of the bytes shifted out.
   localparam logic [1:0] SRC_ARRAY  = 2'h0;
   localparam logic [1:0] SRC_IDPAGE = 2'h1;
   localparam logic [1:0] SRC_LOCK   = 2'h2;
   localparam logic [1:0] SRC_STATUS = 2'h3;

   // Selection states, Gray coded along the usual path.
   typedef enum logic [2:0] {
      SERC_IDLE   = 3'b000,
      SERC_OPCODE = 3'b001,
      SERC_ADDR   = 3'b011,
      SERC_DATA   = 3'b010,
      SERC_WRDATA = 3'b110,
      SERC_IGNORE = 3'b111
   } serc_state_e;

endpackage

// ==== hdl/serc_sync.sv ====
`timescale 1ns/1ps
module serc_sync #(
   parameter int             W       = 4,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   // Clock, reset and enable.
   input  wire logic         sys_clk_in,
   input  wire logic         rstn_in,
   input  wire logic         ce_in,
   // Asynchronous levels in, synchronised levels out.
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta;

   // Two flip-flops per bit; the first stage feeds only the second.
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge sys_clk_in or negedge rstn_in) begin
         if (!rstn_in) begin
            meta[i]     <= RST_VAL[i];
            sync_out[i] <= RST_VAL[i];
         end else if (ce_in) begin
            meta[i]     <= async_in[i];
            sync_out[i] <= meta[i];
         end
      end
   end

endmodule // serc_sync

// ==== hdl/serc_mem.sv ====
`timescale 1ns/1ps
module serc_mem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   // Clock, reset and enable.
   input  wire logic          sys_clk_in,
   input  wire logic          rstn_in,
   input  wire logic          ce_in,
   // Write port.
   input  wire logic          wr_en_in,
   input  wire logic [AW-1:0] wr_addr_in,
   input  wire logic [DW-1:0] wr_data_in,
   // Read port, data one cycle after the address.
   input  wire logic [AW-1:0] rd_addr_in,
   output logic      [DW-1:0] rd_data_out
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Storage is not reset; only the read register is.
   always_ff @(posedge sys_clk_in) begin
      if (ce_in && wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // Registered read data.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_data_out <= '0;
      end else if (ce_in) begin
         rd_data_out <= mem[rd_addr_in];
      end
   end

endmodule // serc_mem

// ==== tb/serc_host_model.sv ====
`timescale 1ns/1ps
// Host end of the serial link in mode 0, paced by the falling system clock edge.
module serc_host_model (
   // System clock that paces every pin change.
   input  wire logic sys_clk_in,
   // Serial output of the device and its enable.
   input  wire logic so_in,
   input  wire logic so_oe_in,
   // Link pins towards the device.
   output logic      cs_n_out,
   output logic      sck_out,
   output logic      si_out,
   output logic      hold_n_out
);
   logic last_so = 1'b0;
   logic so_wire;
   logic hold_oe = 1'b1;

   // A released line shows the inverse of its last value, so a float never reads as data.
   always_ff @(posedge sys_clk_in) begin
      if (so_oe_in) begin
         last_so <= so_in;
      end
   end
   assign so_wire = so_oe_in ? so_in : ~last_so;

   // Idle pins: deselected, clock low, hold off.
   initial begin
      cs_n_out   = 1'b1;
      sck_out    = 1'b0;
      si_out     = 1'b0;
      hold_n_out = 1'b1;
   end

   // Half a link clock period: four system cycles, 100 ns.
   task automatic half();
      repeat (4) @(negedge sys_clk_in);
   endtask

   // Selection starts with the clock low.
   task automatic select();
      half();
      cs_n_out = 1'b0;
      half();
   endtask

   // One byte out on SI and one byte in from SO, sampled at the end of each high phase.
   task automatic shift(input logic [7:0] tx, input bit pause, output logic [7:0] rx,
                        output logic oe_any);
      oe_any = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         sck_out = 1'b0;
         si_out  = tx[i];
         if (pause && i == 7) begin
            half();
            hold_n_out = 1'b0;
            half();
            si_out  = ~tx[i];
            sck_out = 1'b1;
            half();
            hold_oe = so_oe_in;
            sck_out = 1'b0;
            si_out  = tx[i];
            half();
            hold_n_out = 1'b1;
         end
         half();
         sck_out = 1'b1;
         half();
         rx[i]  = so_wire;
         oe_any = oe_any | so_oe_in;
      end
   endtask

   // The clock goes low before select rises, ending the transfer.
   task automatic deselect();
      half();
      sck_out = 1'b0;
      half();
      cs_n_out = 1'b1;
      half();
   endtask
endmodule // serc_host_model

// ==== tb/spi_eeprom_read_hold_ctrl_tb.sv ====
`timescale 1ns/1ps
// Bench for the read controller: command sequences through the host model.
module spi_eeprom_read_hold_ctrl_tb;
   import serc_pkg::*;
   logic sys_clk = 1'b0, rstn = 1'b0, busy = 1'b0, done_p = 1'b0, locked = 1'b0;
   logic [7:0] status = 8'h00, mem_data = 8'h00, w_op, w_data;
   logic mem_en = 1'b0, mem_id = 1'b0, cs_n, sck, si, hold_n, so, so_oe, w_start, w_byte, wel;
   logic [16:0] mem_addr = 17'h00000;
   logic [23:0] w_addr;
   logic [7:0] rx_q[$];
   logic       oe_q[$];
   int fail_count = 0, tests_run = 0, cycles = 0, starts = 0, s0;

   // 40 MHz system clock.
   always #12.5 sys_clk = ~sys_clk;

   serc_read_ctrl i_dut (.sys_clk_in(sys_clk), .rstn_in(rstn), .ce_in(1'b1),
      .spi_cs_n_in(cs_n), .spi_sck_in(sck), .spi_si_in(si), .spi_hold_n_in(hold_n),
      .spi_so_out(so), .spi_so_oe_out(so_oe), .status_in(status), .id_locked_in(locked),
      .write_busy_in(busy), .write_done_in(done_p), .write_start_out(w_start),
      .write_byte_out(w_byte), .write_opcode_out(w_op), .write_addr_out(w_addr),
      .write_data_out(w_data), .wel_out(wel), .mem_wr_en_in(mem_en), .mem_wr_id_in(mem_id),
      .mem_wr_addr_in(mem_addr), .mem_wr_data_in(mem_data));

   serc_host_model i_host (.sys_clk_in(sys_clk), .so_in(so), .so_oe_in(so_oe),
      .cs_n_out(cs_n), .sck_out(sck), .si_out(si), .hold_n_out(hold_n));

   // Counts write start pulses and cuts a hung run short.
   always @(negedge sys_clk) begin
      cycles++;
      if (w_start === 1'b1) starts++;
      if (cycles == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Loads one byte of the array or the id page through the load port.
   task automatic load(input logic id, input logic [16:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      mem_en   = 1'b1;
      mem_id   = id;
      mem_addr = a;
      mem_data = d;
      @(negedge sys_clk);
      mem_en = 1'b0;
   endtask

   // One selection: opcode, optional address, then n data bytes of wd, pause at byte p.
   task automatic xfer(input logic [7:0] op, input logic [23:0] a, input bit use_a,
                       input int n, input int p, input logic [7:0] wd);
      logic [7:0] r;
      logic       o;
      rx_q = {};
      oe_q = {};
      i_host.select();
      i_host.shift(op, 1'b0, r, o);
      if (use_a) for (int k = 2; k >= 0; k--) i_host.shift(a[k*8 +: 8], 1'b0, r, o);
      for (int j = 0; j < n; j++) begin
         i_host.shift(wd, j == p, r, o);
         rx_q.push_back(r);
         oe_q.push_back(o);
      end
      i_host.deselect();
      repeat (4) @(negedge sys_clk);
   endtask

   initial begin
      repeat (3) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (4) @(negedge sys_clk);
      check(wel, 1'b0);
      check(so_oe, 1'b0);
      $display("test reset done");
      load(1'b0, 17'h1fffe, 8'ha5);
      load(1'b0, 17'h1ffff, 8'h3c);
      load(1'b0, 17'h00000, 8'h96);
      load(1'b0, 17'h00001, 8'he1);
      load(1'b1, 17'h00010, 8'h5a);
      load(1'b1, 17'h00011, 8'hc3);
      // Array read across the top address, paused by hold in the third byte.
      xfer(8'h03, 24'hfffffe, 1, 4, 2, 8'h00);
      check({rx_q[0], rx_q[1], rx_q[2], rx_q[3]}, 32'ha53c96e1);
      check(i_host.hold_oe, 1'b0);
      check(so_oe, 1'b0);
      $display("test array read done");
      xfer(8'h83, 24'hfffb10, 1, 2, -1, 8'h00);
      check({rx_q[0], rx_q[1]}, 16'h5ac3);
      $display("test id page done");
      for (int lk = 0; lk < 2; lk++) begin
         @(negedge sys_clk);
         locked = lk[0];
         busy   = lk[0];
         xfer(8'h83, 24'h000400, 1, 1, -1, 8'h00);
         check(rx_q[0], {7'h00, lk[0]});
         status = 8'ha4;
         xfer(8'h05, 24'h000000, 0, 2, -1, 8'h00);
         check({rx_q[0], rx_q[1]}, {8'ha4 | lk[0], 8'ha4 | lk[0]});
      end
      xfer(8'h03, 24'h000000, 1, 1, -1, 8'h00);
      check(oe_q[0], 1'b0);
      xfer(8'h83, 24'h000010, 1, 1, -1, 8'h00);
      check(oe_q[0], 1'b0);
      @(negedge sys_clk);
      busy = 1'b0;
      xfer(8'hff, 24'h000000, 0, 1, -1, 8'h00);
      check(oe_q[0], 1'b0);
      $display("test status and refusals done");
      s0 = starts;
      xfer(8'h02, 24'h000123, 1, 1, -1, 8'h5b);
      check(starts - s0, 0);
      xfer(8'h06, 24'h000000, 0, 0, -1, 8'h00);
      check(wel, 1'b1);
      xfer(8'h02, 24'h000123, 1, 1, -1, 8'h5b);
      check(starts - s0, 1);
      check({w_addr, w_data}, 32'h0001235b);
      @(negedge sys_clk);
      done_p = 1'b1;
      @(negedge sys_clk);
      done_p = 1'b0;
      @(negedge sys_clk);
      check(wel, 1'b0);
      $display("test write hand-off done");
      report_and_stop();
   end
endmodule // spi_eeprom_read_hold_ctrl_tb
